// *** sim/pdo_pin_world.sv ***
// model of the circuitry on the pads: drivers, pull-ups, floating pins
`timescale 1ns/1ps
`default_nettype none

module pdo_pin_world (
    input wire logic clk_i,
    input wire logic [31:0] pad_out_i,
    input wire logic [31:0] pad_oe_i,
    input wire logic [31:0] pad_pullup_i,
    input wire logic [31:0] ext_drive_i,
    input wire logic [31:0] ext_level_i,
    output logic [31:0] pad_in_o
);
    logic [31:0] float_q = 32'h0;

    // a floating pin toggles so no stale level can pass for a real one
    always @(posedge clk_i)
        float_q <= ~float_q;

    // device drive wins, then outside driver, then pull-up, else noise
    assign pad_in_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_drive_i &
        ext_level_i) | (~pad_oe_i & ~ext_drive_i & (pad_pullup_i | float_q));
endmodule

`default_nettype wire

// *** sim/pdo_port_block_tb.sv ***
// self-checking bench for the port block: registers, overrides, pins
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
    error_cnt++; $display("[FAIL] %s exp %h got %h", nm, ex, got); end end

module pdo_port_block_tb
    import pdo_pkg::*;
;
    typedef struct {logic w; logic [7:0] a; logic [31:0] d, x; logic e;}
        pdo_row_s;
    logic clk_i = 1'h0, reset_n_i = 1'h0, psel_i = 1'h0, penable_i = 1'h0;
    logic pwrite_i = 1'h0, input_gate_i = 1'h0, receiver_on_i = 1'h0;
    logic transmitter_on_i = 1'h0, tx_serial_data_i = 1'h0;
    logic timer2_compare_en_i = 1'h0, timer2_compare_out_i = 1'h0;
    logic timer1_compare_a_en_i = 1'h0, timer1_compare_a_out_i = 1'h0;
    logic timer1_compare_b_en_i = 1'h0, timer1_compare_b_out_i = 1'h0;
    logic ext_irq_zero_en_i = 1'h0, ext_irq_one_en_i = 1'h0;
    logic [7:0] paddr_i = 8'h0;
    logic [31:0] pwdata_i = 32'h0, ext_drive = 32'h0, ext_level = 32'h0;
    wire logic [31:0] pad_in_i;
    logic [31:0] prdata_o, pad_out_o, pad_oe_o, pad_pullup_o, rd;
    logic pready_o, pslverr_o, rx_serial_data_o, timer1_capture_in_o, er;
    logic ext_irq_zero_in_o, ext_irq_one_in_o;
    logic [7:0] special_function_io_o;
    int error_cnt = 0, n_checks = 0, cyc = 0;
    // reads of reset values, write/readback, read-only bit, unmapped slot
    pdo_row_s rows[10] = '{
        '{1'h0, PDO_OFF_SPECIAL_FUNCTION_IO, 32'h0, 32'h0, 1'h0},
        '{1'h0, PDO_OFF_PORT_A_OUTPUT_LATCH, 32'h0, 32'h0, 1'h0},
        '{1'h0, PDO_OFF_PORT_D_DIRECTION, 32'h0, 32'h0, 1'h0},
        '{1'h1, PDO_OFF_PORT_A_OUTPUT_LATCH, 32'h5a, 32'h0, 1'h0},
        '{1'h0, PDO_OFF_PORT_A_OUTPUT_LATCH, 32'h0, 32'h5a, 1'h0},
        '{1'h1, PDO_OFF_PORT_B_DIRECTION, 32'hc3, 32'h0, 1'h0},
        '{1'h0, PDO_OFF_PORT_B_DIRECTION, 32'h0, 32'hc3, 1'h0},
        '{1'h1, PDO_OFF_SPECIAL_FUNCTION_IO, 32'hff, 32'h0, 1'h0},
        '{1'h0, PDO_OFF_SPECIAL_FUNCTION_IO, 32'h0, 32'hef, 1'h0},
        '{1'h0, 8'h34, 32'h0, 32'h0, 1'h1}};

    always #10 clk_i = ~clk_i;

    pdo_port_block i_pdo_port_block (.clk_i, .reset_n_i, .psel_i, .penable_i,
        .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
        .pad_in_i, .pad_out_o, .pad_oe_o, .pad_pullup_o, .input_gate_i,
        .receiver_on_i, .transmitter_on_i, .tx_serial_data_i,
        .timer2_compare_en_i, .timer2_compare_out_i, .timer1_compare_a_en_i,
        .timer1_compare_a_out_i, .timer1_compare_b_en_i,
        .timer1_compare_b_out_i, .ext_irq_zero_en_i, .ext_irq_one_en_i,
        .rx_serial_data_o, .timer1_capture_in_o, .ext_irq_zero_in_o,
        .ext_irq_one_in_o, .special_function_io_o);
    pdo_pin_world i_pdo_pin_world (.clk_i, .pad_out_i(pad_out_o),
        .pad_oe_i(pad_oe_o), .pad_pullup_i(pad_pullup_o),
        .ext_drive_i(ext_drive), .ext_level_i(ext_level), .pad_in_o(pad_in_i));

    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // one apb transfer, entered just after a rising edge; idle edge after
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        psel_i <= 1'h1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'h1;
        do @(posedge clk_i); while (pready_o !== 1'h1);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'h0;
        penable_i <= 1'h0;
        @(posedge clk_i);
    endtask

    // cut a hang short
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 4000)
        begin
            error_cnt++;
            print_verdict();
        end
    end

    initial
    begin
        repeat (6) @(posedge clk_i);
        reset_n_i <= 1'h1;
        @(posedge clk_i);
        foreach (rows[i])
        begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w)
                `CHK("read data", rows[i].x, rd)
            `CHK("slave error", rows[i].e, er)
        end
        `CHK("special out", 8'hef, special_function_io_o)
        // -------------------------------------------------------------
        // pull-ups, receive and transmit overrides
        // -------------------------------------------------------------
        apb(1'h1, PDO_OFF_PORT_C_OUTPUT_LATCH, 32'hff);
        `CHK("pullups off", 32'h0, pad_pullup_o)
        apb(1'h1, PDO_OFF_SPECIAL_FUNCTION_IO, 32'h0);
        `CHK("pullups", 32'h00ff005a, pad_pullup_o)
        apb(1'h1, PDO_OFF_PORT_D_DIRECTION, 32'h81);
        apb(1'h1, PDO_OFF_PORT_D_OUTPUT_LATCH, 32'h03);
        receiver_on_i <= 1'h1;
        ext_drive <= 32'h01000000;
        ext_level <= 32'h01000000;
        repeat (5) @(posedge clk_i);
        @(negedge clk_i);
        `CHK("rx oe", 1'h0, pad_oe_o[24])
        `CHK("rx pullup", 1'h1, pad_pullup_o[24])
        `CHK("rx data", 1'h1, rx_serial_data_o)
        `CHK("tx idle pullup", 1'h1, pad_pullup_o[25])
        @(posedge clk_i);
        apb(1'h1, PDO_OFF_SPECIAL_FUNCTION_IO, 32'h04);
        `CHK("rx pullup off", 1'h0, pad_pullup_o[24])
        apb(1'h1, PDO_OFF_SPECIAL_FUNCTION_IO, 32'h0);
        transmitter_on_i <= 1'h1;
        @(negedge clk_i);
        `CHK("tx pin", 3'h4, {pad_oe_o[25], pad_pullup_o[25], pad_out_o[25]})
        @(posedge clk_i);
        tx_serial_data_i <= 1'h1;
        @(negedge clk_i);
        `CHK("tx data", 1'h1, pad_out_o[25])
        // -------------------------------------------------------------
        // compare outputs, interrupt and capture inputs, pin levels
        // -------------------------------------------------------------
        @(posedge clk_i);
        apb(1'h1, PDO_OFF_PORT_D_OUTPUT_LATCH, 32'h0);
        {timer2_compare_en_i, timer2_compare_out_i} <= 2'h3;
        {timer1_compare_a_en_i, timer1_compare_a_out_i} <= 2'h3;
        {timer1_compare_b_en_i, timer1_compare_b_out_i} <= 2'h3;
        @(negedge clk_i);
        `CHK("compare out", 4'hb, pad_out_o[31:28])
        `CHK("compare oe", 4'h8, pad_oe_o[31:28])
        @(posedge clk_i);
        timer2_compare_en_i <= 1'h0;
        timer1_compare_a_en_i <= 1'h0;
        timer1_compare_b_en_i <= 1'h0;
        input_gate_i <= 1'h1;
        ext_irq_zero_en_i <= 1'h1;
        ext_irq_one_en_i <= 1'h1;
        ext_drive <= 32'h4c000000;
        ext_level <= 32'h4c000000;
        repeat (5) @(posedge clk_i);
        @(negedge clk_i);
        `CHK("latch back", 4'h0, pad_out_o[31:28])
        `CHK("irq pins", 2'h3, {ext_irq_one_in_o, ext_irq_zero_in_o})
        `CHK("capture gated", 1'h0, timer1_capture_in_o)
        @(posedge clk_i);
        input_gate_i <= 1'h0;
        ext_drive <= 32'h4000ff00;
        ext_level <= 32'h4000a500;
        repeat (5) @(posedge clk_i);
        @(negedge clk_i);
        `CHK("capture", 1'h1, timer1_capture_in_o)
        @(posedge clk_i);
        apb(1'h0, PDO_OFF_PORT_B_PIN_LEVELS, 32'h0);
        `CHK("pin levels", 32'h24, rd)
        apb(1'h1, PDO_OFF_PORT_B_PIN_LEVELS, 32'h0);
        `CHK("pin levels wr err", 1'h0, er)
        apb(1'h0, PDO_OFF_PORT_B_PIN_LEVELS, 32'h0);
        `CHK("pin levels ro", 32'h24, rd)
        // second reset in mid-run returns every pin to input
        receiver_on_i <= 1'h0;
        transmitter_on_i <= 1'h0;
        reset_n_i <= 1'h0;
        @(negedge clk_i);
        `CHK("reset oe", 32'h0, pad_oe_o | pad_pullup_o)
        @(posedge clk_i);
        reset_n_i <= 1'h1;
        @(posedge clk_i);
        apb(1'h0, PDO_OFF_PORT_A_OUTPUT_LATCH, 32'h0);
        `CHK("reset latch", 32'h0, rd)
        print_verdict();
    end
endmodule

`default_nettype wire

// *** sim/pdo_port_monitor.sv ***
// pin-level checker for the port block, bound to its top module
`timescale 1ns/1ps
`default_nettype none

module pdo_port_monitor (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [31:0] pad_in_i,
    input wire logic [31:0] pad_out_o,
    input wire logic [31:0] pad_oe_o,
    input wire logic [31:0] pad_pullup_o,
    input wire logic input_gate_i,
    input wire logic receiver_on_i,
    input wire logic transmitter_on_i,
    input wire logic tx_serial_data_i,
    input wire logic timer2_compare_en_i,
    input wire logic timer2_compare_out_i,
    input wire logic timer1_compare_a_en_i,
    input wire logic timer1_compare_a_out_i,
    input wire logic ext_irq_zero_en_i,
    input wire logic ext_irq_zero_in_o,
    input wire logic timer1_capture_in_o,
    input wire logic [7:0] special_function_io_o
);
    // all checks share the one clock and its reset
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    a_rx_forced_in: assert property (receiver_on_i |-> !pad_oe_o[24])
        else $error("rx pin driven while receiver on");
    a_tx_takes_pin:
        assert property (transmitter_on_i |-> pad_oe_o[25] && !pad_pullup_o[25]
            && pad_out_o[25] == tx_serial_data_i) else $error("tx pin not taken");
    a_pullup_kill:
        assert property (special_function_io_o[2] |-> pad_pullup_o == 32'h0)
        else $error("pullup on while globally off");
    a_t2_compare:
        assert property (timer2_compare_en_i |->
            pad_out_o[31] == timer2_compare_out_i) else $error("t2 out lost");
    a_t1a_compare:
        assert property (timer1_compare_a_en_i |->
            pad_out_o[29] == timer1_compare_a_out_i) else $error("t1a out lost");
    a_bit4_zero:
        assert property (special_function_io_o[4] == 1'h0)
        else $error("special bit 4 set");
    a_pullup_input:
        assert property ((pad_pullup_o & pad_oe_o) == 32'h0)
        else $error("pullup on a driven pin");
    // five stable samples cover the three-edge input path with margin
    a_irq_zero_pass:
        assert property ((ext_irq_zero_en_i && $stable(pad_in_i[26]))[*5] |->
            ext_irq_zero_in_o == pad_in_i[26]) else $error("irq0 not passed");
    a_capture_pass:
        assert property ((!input_gate_i && $stable(pad_in_i[30]))[*5] |->
            timer1_capture_in_o == pad_in_i[30]) else $error("capture lost");
endmodule

bind pdo_port_block pdo_port_monitor i_pdo_port_monitor (.clk_i, .reset_n_i,
    .pad_in_i, .pad_out_o, .pad_oe_o, .pad_pullup_o, .input_gate_i,
    .receiver_on_i, .transmitter_on_i, .tx_serial_data_i,
    .timer2_compare_en_i, .timer2_compare_out_i, .timer1_compare_a_en_i,
    .timer1_compare_a_out_i, .ext_irq_zero_en_i, .ext_irq_zero_in_o,
    .timer1_capture_in_o, .special_function_io_o);

`default_nettype wire

// *** src/pdo_pkg.sv ***
// constants shared by the port logic: register map, field positions, resets
package pdo_pkg;

    // ------------------------------------------------------------------
    // register byte offsets on the apb slave
    // ------------------------------------------------------------------
    localparam logic [7:0] PDO_OFF_SPECIAL_FUNCTION_IO = 8'h00;
    localparam logic [7:0] PDO_OFF_PORT_A_OUTPUT_LATCH = 8'h04;
    localparam logic [7:0] PDO_OFF_PORT_A_DIRECTION = 8'h08;
    localparam logic [7:0] PDO_OFF_PORT_A_PIN_LEVELS = 8'h0c;
    localparam logic [7:0] PDO_OFF_PORT_B_OUTPUT_LATCH = 8'h10;
    localparam logic [7:0] PDO_OFF_PORT_B_DIRECTION = 8'h14;
    localparam logic [7:0] PDO_OFF_PORT_B_PIN_LEVELS = 8'h18;
    localparam logic [7:0] PDO_OFF_PORT_C_OUTPUT_LATCH = 8'h1c;
    localparam logic [7:0] PDO_OFF_PORT_C_DIRECTION = 8'h20;
    localparam logic [7:0] PDO_OFF_PORT_C_PIN_LEVELS = 8'h24;
    localparam logic [7:0] PDO_OFF_PORT_D_OUTPUT_LATCH = 8'h28;
    localparam logic [7:0] PDO_OFF_PORT_D_DIRECTION = 8'h2c;
    localparam logic [7:0] PDO_OFF_PORT_D_PIN_LEVELS = 8'h30;

    // ------------------------------------------------------------------
    // special function register fields and reset values
    // ------------------------------------------------------------------
    localparam int PDO_SFIO_PULLUP_OFF_BIT = 2;
    localparam logic [7:0] PDO_SFIO_RO_ZERO_MASK = 8'h10;
    localparam logic [7:0] PDO_SFIO_RESET = 8'h00;
    localparam logic [7:0] PDO_LATCH_RESET = 8'h00;
    localparam logic [7:0] PDO_DIRECTION_RESET = 8'h00;

    // ------------------------------------------------------------------
    // pin positions of the fourth port, counted in the 32-bit pad vector
    // ------------------------------------------------------------------
    localparam int PDO_PORT_D_BASE = 24;
    localparam int PDO_PIN_RX = PDO_PORT_D_BASE + 0;
    localparam int PDO_PIN_TX = PDO_PORT_D_BASE + 1;
    localparam int PDO_PIN_IRQ0 = PDO_PORT_D_BASE + 2;
    localparam int PDO_PIN_IRQ1 = PDO_PORT_D_BASE + 3;
    localparam int PDO_PIN_T1B = PDO_PORT_D_BASE + 4;
    localparam int PDO_PIN_T1A = PDO_PORT_D_BASE + 5;
    localparam int PDO_PIN_CAPTURE = PDO_PORT_D_BASE + 6;
    localparam int PDO_PIN_T2 = PDO_PORT_D_BASE + 7;

endpackage

// *** src/pdo_port_block.sv ***
// four 8-bit ports with the fourth port's alternate-function overrides
//
// Functional notes
// - receiver on forces rx pin to input
// - rx pullup follows latch bit, global off
// - global pullup off kills every pullup
// - transmitter on: no pullup, output, serial data
// - compare outputs replace latch when enabled
// - capture pin feeds timer, no overrides
// - enabled external irq forces input enable
// - latch and direction reset to zero
// - pin levels read-only sampled pin state
// - special register: bit2 pullup off, bit4 zero
// - transmitter on makes tx pin output
`timescale 1ns/1ps
`default_nettype none

module pdo_port_block
    import pdo_pkg::*;
#(
    parameter int NUM_PORTS = 4,
    parameter int PORT_WIDTH = 8
)
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // pads: a=7:0, b=15:8, c=23:16, d=31:24
    input wire logic [31:0] pad_in_i,
    output logic [31:0] pad_out_o,
    output logic [31:0] pad_oe_o,
    output logic [31:0] pad_pullup_o,
    // high closes the digital inputs of pins that no unit holds open
    input wire logic input_gate_i,
    // peripheral side
    input wire logic receiver_on_i,
    input wire logic transmitter_on_i,
    input wire logic tx_serial_data_i,
    input wire logic timer2_compare_en_i,
    input wire logic timer2_compare_out_i,
    input wire logic timer1_compare_a_en_i,
    input wire logic timer1_compare_a_out_i,
    input wire logic timer1_compare_b_en_i,
    input wire logic timer1_compare_b_out_i,
    input wire logic ext_irq_zero_en_i,
    input wire logic ext_irq_one_en_i,
    output logic rx_serial_data_o,
    output logic timer1_capture_in_o,
    output logic ext_irq_zero_in_o,
    output logic ext_irq_one_in_o,
    output logic [7:0] special_function_io_o
);

    localparam int NPINS = NUM_PORTS * PORT_WIDTH;

    // ------------------------------------------------------------------
    // register state
    // ------------------------------------------------------------------
    logic [7:0] special_function_io_q;
    logic [NPINS-1:0] output_latch_q;
    logic [NPINS-1:0] direction_q;
    // pad levels reach the units three edges late: two sync flops, one reg
    logic [NPINS-1:0] pin_sync1_q;
    logic [NPINS-1:0] pin_sync2_q;
    logic [NPINS-1:0] pin_levels_q;
    logic global_pullup_off;

    // override bundles, one bit per pin
    logic [NPINS-1:0] pullup_override_en;
    logic [NPINS-1:0] pullup_override_val;
    logic [NPINS-1:0] direction_override_en;
    logic [NPINS-1:0] direction_override_val;
    logic [NPINS-1:0] pin_value_override_en;
    logic [NPINS-1:0] pin_value_override_val;
    logic [NPINS-1:0] input_enable_override_en;
    logic [NPINS-1:0] input_enable_override_val;
    logic [NPINS-1:0] input_enable_eff;

    // write strobe and hit on a mapped register
    logic wr_en;
    logic addr_hit;

    // one disable bit serves the register path and the rx override alike
    assign global_pullup_off = special_function_io_q[PDO_SFIO_PULLUP_OFF_BIT];

    // ------------------------------------------------------------------
    // apb slave: zero wait states, error on unmapped address
    // ------------------------------------------------------------------
    // always ready, so every access phase ends in its first cycle
    assign pready_o = 1'b1;
    // a miss raises no strobe, so an unmapped write leaves all state alone
    assign wr_en = psel_i & penable_i & pwrite_i & addr_hit;

    // address decode and read mux; upper 24 bits read as zero
    always_comb
    begin
        addr_hit = 1'b1;
        prdata_o = 32'h0000_0000;
        unique case (paddr_i)
            PDO_OFF_SPECIAL_FUNCTION_IO:
                prdata_o[7:0] = special_function_io_q;
            PDO_OFF_PORT_A_OUTPUT_LATCH: prdata_o[7:0] = output_latch_q[7:0];
            PDO_OFF_PORT_A_DIRECTION: prdata_o[7:0] = direction_q[7:0];
            PDO_OFF_PORT_A_PIN_LEVELS: prdata_o[7:0] = pin_levels_q[7:0];
            PDO_OFF_PORT_B_OUTPUT_LATCH: prdata_o[7:0] = output_latch_q[15:8];
            PDO_OFF_PORT_B_DIRECTION: prdata_o[7:0] = direction_q[15:8];
            PDO_OFF_PORT_B_PIN_LEVELS: prdata_o[7:0] = pin_levels_q[15:8];
            PDO_OFF_PORT_C_OUTPUT_LATCH: prdata_o[7:0] = output_latch_q[23:16];
            PDO_OFF_PORT_C_DIRECTION: prdata_o[7:0] = direction_q[23:16];
            PDO_OFF_PORT_C_PIN_LEVELS: prdata_o[7:0] = pin_levels_q[23:16];
            PDO_OFF_PORT_D_OUTPUT_LATCH: prdata_o[7:0] = output_latch_q[31:24];
            PDO_OFF_PORT_D_DIRECTION: prdata_o[7:0] = direction_q[31:24];
            PDO_OFF_PORT_D_PIN_LEVELS: prdata_o[7:0] = pin_levels_q[31:24];
            default: addr_hit = 1'b0;
        endcase
    end

    // pin-level slots are mapped, so writes there are dropped quietly
    // error only in the access phase, so a setup cycle never flags it
    assign pslverr_o = psel_i & penable_i & ~addr_hit;

    // ------------------------------------------------------------------
    // special function register
    // ------------------------------------------------------------------
    // the bits of other units are kept as written for them to read back
    // bit4 held zero
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            special_function_io_q <= PDO_SFIO_RESET;
        else if (wr_en && paddr_i == PDO_OFF_SPECIAL_FUNCTION_IO)
            special_function_io_q <= pwdata_i[7:0] & ~PDO_SFIO_RO_ZERO_MASK;
    end

    // other units own the remaining bits; they see the stored byte
    assign special_function_io_o = special_function_io_q;

    // ------------------------------------------------------------------
    // output latch and direction registers
    // ------------------------------------------------------------------
    // one byte lane per port; pin-level offsets fall to the default arm
    // latch writes, reset zero
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            output_latch_q <= {NUM_PORTS{PDO_LATCH_RESET}};
        else if (wr_en)
        begin
            unique case (paddr_i)
                PDO_OFF_PORT_A_OUTPUT_LATCH: output_latch_q[7:0] <= pwdata_i[7:0];
                PDO_OFF_PORT_B_OUTPUT_LATCH: output_latch_q[15:8] <= pwdata_i[7:0];
                PDO_OFF_PORT_C_OUTPUT_LATCH: output_latch_q[23:16] <= pwdata_i[7:0];
                PDO_OFF_PORT_D_OUTPUT_LATCH: output_latch_q[31:24] <= pwdata_i[7:0];
                default: ;
            endcase
        end
    end

    // a cleared bit leaves its pin an input, the safe state at power-up
    // direction writes, reset input
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            direction_q <= {NUM_PORTS{PDO_DIRECTION_RESET}};
        else if (wr_en)
        begin
            unique case (paddr_i)
                PDO_OFF_PORT_A_DIRECTION: direction_q[7:0] <= pwdata_i[7:0];
                PDO_OFF_PORT_B_DIRECTION: direction_q[15:8] <= pwdata_i[7:0];
                PDO_OFF_PORT_C_DIRECTION: direction_q[23:16] <= pwdata_i[7:0];
                PDO_OFF_PORT_D_DIRECTION: direction_q[31:24] <= pwdata_i[7:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // pin sampling
    // ------------------------------------------------------------------
    // two flops against metastability; only the second is read below
    // their reset value means nothing: the pad is unknown until sampled
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            pin_sync1_q <= '0;
            pin_sync2_q <= '0;
        end
        else
        begin
            pin_sync1_q <= pad_in_i;
            pin_sync2_q <= pin_sync1_q;
        end
    end

    // a closed gate reads zero, so a floating pad cannot toggle logic
    // sampled levels, gated input
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            pin_levels_q <= '0;
        else
            pin_levels_q <= pin_sync2_q & input_enable_eff;
    end

    // ------------------------------------------------------------------
    // fourth-port override sources
    // ------------------------------------------------------------------
    // pins without an alternate function keep every enable low
    // defaults first keep this process free of latches
    always_comb
    begin
        pullup_override_en = '0;
        pullup_override_val = '0;
        direction_override_en = '0;
        direction_override_val = '0;
        pin_value_override_en = '0;
        pin_value_override_val = '0;
        input_enable_override_en = '0;
        input_enable_override_val = '0;
        // value zero: the receiver only listens on its pin
        // receiver forces input
        pullup_override_en[PDO_PIN_RX] = receiver_on_i;
        direction_override_en[PDO_PIN_RX] = receiver_on_i;
        direction_override_val[PDO_PIN_RX] = 1'b0;
        pullup_override_val[PDO_PIN_RX] =
            output_latch_q[PDO_PIN_RX] & ~global_pullup_off;
        // no pull-up while driving: it would only load the transmitter
        // transmitter takes pin
        pullup_override_en[PDO_PIN_TX] = transmitter_on_i;
        pullup_override_val[PDO_PIN_TX] = 1'b0;
        pin_value_override_en[PDO_PIN_TX] = transmitter_on_i;
        pin_value_override_val[PDO_PIN_TX] = tx_serial_data_i;
        // drive enable high whatever the direction register holds
        // tx pin forced output
        direction_override_en[PDO_PIN_TX] = transmitter_on_i;
        direction_override_val[PDO_PIN_TX] = 1'b1;
        // drive is untouched: a pin set as output still reaches its irq
        // irq forces input enable
        input_enable_override_en[PDO_PIN_IRQ0] = ext_irq_zero_en_i;
        input_enable_override_val[PDO_PIN_IRQ0] = 1'b1;
        input_enable_override_en[PDO_PIN_IRQ1] = ext_irq_one_en_i;
        input_enable_override_val[PDO_PIN_IRQ1] = 1'b1;
        // direction stays with software: an input pin hides the compare
        // compare outputs replace latch
        pin_value_override_en[PDO_PIN_T1B] = timer1_compare_b_en_i;
        pin_value_override_val[PDO_PIN_T1B] = timer1_compare_b_out_i;
        pin_value_override_en[PDO_PIN_T1A] = timer1_compare_a_en_i;
        pin_value_override_val[PDO_PIN_T1A] = timer1_compare_a_out_i;
        pin_value_override_en[PDO_PIN_T2] = timer2_compare_en_i;
        pin_value_override_val[PDO_PIN_T2] = timer2_compare_out_i;
        // capture reads the pad through the ordinary input gate
        // capture pin left untouched
        pin_value_override_en[PDO_PIN_CAPTURE] = 1'b0;
    end

    // ------------------------------------------------------------------
    // per-pin override muxes
    // ------------------------------------------------------------------
    // overrides come first; registers fill in whatever no unit claims
    // register path: pullup only when input, latch one and not disabled
    for (genvar i = 0; i < NPINS; i++)
    begin : g_pin
        assign pad_oe_o[i] = direction_override_en[i] ?
            direction_override_val[i] : direction_q[i];
        assign pad_out_o[i] = pin_value_override_en[i] ?
            pin_value_override_val[i] : output_latch_q[i];
        // register path only; the overrides carry their own pull-up value
        // global pullup disable
        assign pad_pullup_o[i] = pullup_override_en[i] ?
            pullup_override_val[i] :
            (~direction_q[i] & output_latch_q[i] & ~global_pullup_off);
        // gate closes inputs in low power, unless an enabled irq holds the pin open
        assign input_enable_eff[i] = input_enable_override_en[i] ?
            input_enable_override_val[i] : ~input_gate_i;
    end

    // ------------------------------------------------------------------
    // digital inputs to the peripherals
    // ------------------------------------------------------------------
    // units see the registered level, never the raw pad
    // rx pin to receiver
    assign rx_serial_data_o = pin_levels_q[PDO_PIN_RX];
    assign timer1_capture_in_o = pin_levels_q[PDO_PIN_CAPTURE];
    assign ext_irq_zero_in_o = pin_levels_q[PDO_PIN_IRQ0];
    assign ext_irq_one_in_o = pin_levels_q[PDO_PIN_IRQ1];

endmodule

`default_nettype wire
